/* File: verilog/signal_modulator.sv */
// data signal modulator top with axi4-lite register slave
// assumes source vectors come from on-chip peripherals on clk_sys
`timescale 1ns/1ps
`include "modulator_regs.svh"
module signal_modulator #(
    parameter int SRC_N = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite write channels
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // signal sources
    input wire logic [SRC_N-1:0] mod_sources,
    input wire logic [SRC_N-1:0] carrier_sources,
    // modulated output pin
    output logic modulator_out
);
    logic [7:0] ctrl_q;
    logic [7:0] src_q;
    logic [7:0] carrier_high_q;
    logic [7:0] carrier_low_q;
    logic [3:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic [7:0] wr_byte;
    logic wr_go;
    logic wr_ok;
    logic modulator_on;
    logic output_invert;
    logic soft_modulator_value;
    logic carrier_high;
    logic carrier_low;
    logic modulator;
    logic mixed;
    logic out_q;
    carrier_if hi_if ();
    carrier_if lo_if ();

    assign modulator_on = ctrl_q[`MOD_ON_BIT];
    assign output_invert = ctrl_q[`MOD_OINV_BIT];
    assign soft_modulator_value = ctrl_q[`MOD_SOFT_BIT];

    // write address and data captured in either order
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_have_q <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (wr_go)
            w_have_q <= 1'b0;
    end

    // decode of the write target
    always_comb
    begin
        wr_ok = 1'b1;
        unique case (awaddr_q)
            `MOD_CTRL_ADDR, `MOD_SRC_ADDR, `MOD_CARRIER_HIGH_ADDR, `MOD_CARRIER_LOW_ADDR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    assign wr_byte = wdata_q[7:0];

    // register writes; only byte lane 0 holds bits
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_q <= `MOD_CTRL_RST;
            src_q <= `MOD_SRC_RST;
            carrier_high_q <= `MOD_CAR_RST;
            carrier_low_q <= `MOD_CAR_RST;
        end
        else if (wr_go && wstrb_q[0])
        begin
            // view bit is never written
            if (awaddr_q == `MOD_CTRL_ADDR)
                ctrl_q <= wr_byte & `MOD_CTRL_WMASK;
            if (awaddr_q == `MOD_SRC_ADDR)
                src_q <= wr_byte & `MOD_SRC_WMASK;
            if (awaddr_q == `MOD_CARRIER_HIGH_ADDR)
                carrier_high_q <= wr_byte & `MOD_CAR_WMASK;
            if (awaddr_q == `MOD_CARRIER_LOW_ADDR)
                carrier_low_q <= wr_byte & `MOD_CAR_WMASK;
        end
    end

    // write response, slverr for unmapped
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read decode, view bit shows the live pin
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `MOD_CTRL_ADDR:
            begin
                rd_byte = ctrl_q;
                rd_byte[`MOD_VIEW_BIT] = out_q;
            end
            `MOD_SRC_ADDR: rd_byte = src_q;
            `MOD_CARRIER_HIGH_ADDR: rd_byte = carrier_high_q;
            `MOD_CARRIER_LOW_ADDR: rd_byte = carrier_low_q;
            default:
            begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // source selection; disabled forces ground and the soft bit
    always_comb
    begin
        if (modulator_on)
        begin
            carrier_high = carrier_sources[carrier_high_q[3:0]];
            carrier_low = carrier_sources[carrier_low_q[3:0]];
            modulator = (src_q[3:0] == `MOD_SEL_SOFT) ? soft_modulator_value
                                                       : mod_sources[src_q[3:0]];
        end
        else
        begin
            carrier_high = 1'b0;
            carrier_low = 1'b0;
            modulator = soft_modulator_value;
        end
    end

    // polarity correction and sync settings into the gates
    assign hi_if.carrier = carrier_high ^ carrier_high_q[`MOD_CINV_BIT];
    assign lo_if.carrier = carrier_low ^ carrier_low_q[`MOD_CINV_BIT];
    assign hi_if.sync_on = carrier_high_q[`MOD_CSYNC_BIT];
    assign lo_if.sync_on = carrier_low_q[`MOD_CSYNC_BIT];
    assign hi_if.want = modulator_on & modulator;
    assign lo_if.want = modulator_on & ~modulator;

    carrier_gate u_gate_hi (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cif(hi_if)
    );

    carrier_gate u_gate_lo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cif(lo_if)
    );

    // or-mix of the high and low carriers, each passed while its gate is active
    assign mixed = modulator_on & ((hi_if.active & hi_if.carrier)
                                 | (lo_if.active & lo_if.carrier));

    // registered pin; output invert applied before the flop
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            out_q <= 1'b0;
        else
            out_q <= mixed ^ output_invert;
    end

    assign modulator_out = out_q;
endmodule : signal_modulator

/* File: verilog/modulator_regs.svh */
// register offsets, field positions and reset values of the modulator
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef MODULATOR_REGS_SVH
`define MODULATOR_REGS_SVH
`define MOD_CTRL_ADDR 4'h0
`define MOD_SRC_ADDR 4'h4
`define MOD_CARRIER_HIGH_ADDR 4'h8
`define MOD_CARRIER_LOW_ADDR 4'hc
`define MOD_ON_BIT 7
`define MOD_OINV_BIT 4
`define MOD_VIEW_BIT 3
`define MOD_SOFT_BIT 0
`define MOD_CINV_BIT 6
`define MOD_CSYNC_BIT 5
`define MOD_CTRL_RST 8'h00
`define MOD_SRC_RST 8'h00
`define MOD_CAR_RST 8'h00
`define MOD_CTRL_WMASK 8'h91
`define MOD_CAR_WMASK 8'h6f
`define MOD_SRC_WMASK 8'h0f
`define MOD_SEL_VSS 4'h0
`define MOD_SEL_SOFT 4'h0
`endif

/* File: verilog/modulator_pkg.sv */
// types shared by the modulator files
// assumes modulator_regs.svh supplies the numbers
package modulator_pkg;
    typedef enum logic [1:0] {
        CAR_IDLE = 2'b00,
        CAR_LIVE = 2'b01,
        CAR_HOLD = 2'b10,
        CAR_WAIT = 2'b11
    } car_state_t;
endpackage : modulator_pkg

/* File: verilog/carrier_if.sv */
// carrier path bundle between the top and a carrier gate
// assumes one clock domain, clk_sys
`timescale 1ns/1ps
interface carrier_if;
    logic carrier;
    logic sync_on;
    logic want;
    logic active;
    modport gate (input carrier, input sync_on, input want, output active);
    modport top (output carrier, output sync_on, output want, input active);
endinterface : carrier_if

/* File: verilog/carrier_gate.sv */
// decides when one carrier is allowed into the modulated output
// assumes the carrier is already selected and polarity corrected
`timescale 1ns/1ps
module carrier_gate (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // carrier path
    carrier_if.gate cif
);
    modulator_pkg::car_state_t state_q;
    logic carrier_q;
    logic fall;

    // falling edge of the carrier
    assign fall = carrier_q & ~cif.carrier;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            carrier_q <= 1'b0;
        else
            carrier_q <= cif.carrier;
    end

    // sync waits for a falling edge on entry and for the carrier to be low on exit
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            state_q <= modulator_pkg::CAR_IDLE;
        else
        begin
            unique case (state_q)
                modulator_pkg::CAR_IDLE:
                    if (cif.want)
                        state_q <= cif.sync_on ? modulator_pkg::CAR_WAIT
                                               : modulator_pkg::CAR_LIVE;
                modulator_pkg::CAR_WAIT:
                    if (!cif.want)
                        state_q <= modulator_pkg::CAR_IDLE;
                    else if (fall || !cif.sync_on)
                        state_q <= modulator_pkg::CAR_LIVE;
                modulator_pkg::CAR_LIVE:
                    if (!cif.want)
                        state_q <= (cif.sync_on && cif.carrier) ? modulator_pkg::CAR_HOLD
                                                                 : modulator_pkg::CAR_IDLE;
                modulator_pkg::CAR_HOLD:
                    if (cif.want)
                        state_q <= modulator_pkg::CAR_LIVE;
                    else if (fall || !cif.carrier)
                        state_q <= modulator_pkg::CAR_IDLE;
            endcase
        end
    end

    // immediate when unsynchronised, state driven otherwise
    assign cif.active = cif.sync_on ? (state_q == modulator_pkg::CAR_LIVE
                                      || state_q == modulator_pkg::CAR_HOLD)
                                    : cif.want;
endmodule : carrier_gate

/* File: test/source_model.sv */
// far side: peripheral outputs feeding the modulator sources
// assumes one clock, clk_sys, and a synchronous active-high reset
`timescale 1ns/1ps
module source_model #(
    parameter int SRC_N = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // source lines
    output logic [SRC_N-1:0] mod_sources,
    output logic [SRC_N-1:0] carrier_sources
);
    logic [4:0] cnt_q;
    // free running count, never paused
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_q + 5'h01;
    end
    // carrier line 0 ground, 1 high, 2 toggling; modulator lines 0 and 2 ground, 1 high; unused lines change every cycle
    assign carrier_sources = {{(SRC_N-3){cnt_q[0]}}, cnt_q[2], 1'b1, 1'b0};
    assign mod_sources = {{(SRC_N-3){cnt_q[0]}}, 1'b0, 1'b1, 1'b0};
endmodule : source_model

/* File: test/signal_modulator_assertions.sv */
// bus and reset checks on the modulator top ports
// assumes it is bound to signal_modulator and sees its ports only
`timescale 1ns/1ps
`include "modulator_regs.svh"
module signal_modulator_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // output pin
    input wire logic modulator_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // answers and their spacing
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
        && s_axi_rresp == 2'b00) else $error("read data upper bits or code wrong");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !modulator_out
        && !s_axi_bvalid && !s_axi_rvalid) else $error("not quiet after reset");
    // control read shows the pin as it stood when the read was taken
    a_view_match: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `MOD_CTRL_ADDR
        |=> s_axi_rdata[`MOD_VIEW_BIT] == $past(modulator_out))
        else $error("view bit differs from output pin");
endmodule : signal_modulator_assertions

bind signal_modulator signal_modulator_assertions u_chk (.*);

/* File: test/signal_modulator_tb.sv */
// self-checking bench: register access and output mixing of the modulator
// assumes source_model drives the sources; bready is held high
`timescale 1ns/1ps
`include "modulator_regs.svh"
module signal_modulator_tb;
    logic clk_sys, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, mod_out;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] msrc, csrc;
    int n_errors = 0;
    int samples_checked = 0;
    // far side and device
    source_model u_src (.clk_sys(clk_sys), .sys_rst(sys_rst), .mod_sources(msrc),
        .carrier_sources(csrc));
    signal_modulator u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mod_sources(msrc), .carrier_sources(csrc),
        .modulator_out(mod_out));
    // clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic print_verdict;
        $display("compares %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask : cmp
    // waits at falling edges until the flag is high, bounded
    task automatic until_hi(ref logic f);
        int g;
        g = 0;
        @(negedge clk_sys);
        while (f !== 1'b1)
        begin
            g++;
            if (g > 64)
            begin
                n_errors++;
                print_verdict();
            end
            @(negedge clk_sys);
        end
    endtask : until_hi
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin
                until_hi(awready);
                @(posedge clk_sys);
                awvalid <= 1'b0;
            end
            begin
                until_hi(wready);
                @(posedge clk_sys);
                wvalid <= 1'b0;
            end
        join
        until_hi(bvalid);
        cmp("bresp", 32'h0, {30'h0, bresp});
        @(posedge clk_sys);
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        until_hi(arready);
        @(posedge clk_sys);
        arvalid <= 1'b0;
        @(posedge clk_sys);
        rready <= 1'b1;
        until_hi(rvalid);
        cmp("rdata", e, rdata);
        cmp("rresp", 32'h0, {30'h0, rresp});
        @(posedge clk_sys);
        rready <= 1'b0;
    endtask : rchk
    task automatic set(input logic [3:0] a, input logic [7:0] d, input logic e);
        wr(a, d, 4'hf);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("modulator_out", {31'h0, e}, {31'h0, mod_out});
        @(posedge clk_sys);
    endtask : set
    task automatic sc_reset_values;
        rchk(`MOD_CTRL_ADDR, 32'h0);
        rchk(`MOD_SRC_ADDR, 32'h0);
        rchk(`MOD_CARRIER_HIGH_ADDR, 32'h0);
        rchk(`MOD_CARRIER_LOW_ADDR, 32'h0);
        wr(`MOD_CTRL_ADDR, 8'h91, 4'h0);
        rchk(`MOD_CTRL_ADDR, 32'h0);
    endtask : sc_reset_values
    task automatic sc_idle_level;
        set(`MOD_CTRL_ADDR, 8'h10, 1'b1);
        rchk(`MOD_CTRL_ADDR, 32'h18);
        set(`MOD_CTRL_ADDR, 8'h08, 1'b0);
        rchk(`MOD_CTRL_ADDR, 32'h0);
    endtask : sc_idle_level
    task automatic sc_mixing;
        wr(`MOD_CARRIER_HIGH_ADDR, 8'h01, 4'hf);
        set(`MOD_CTRL_ADDR, 8'h01, 1'b0);
        rchk(`MOD_CARRIER_HIGH_ADDR, 32'h01);
        set(`MOD_CTRL_ADDR, 8'h81, 1'b1);
        set(`MOD_CTRL_ADDR, 8'h80, 1'b0);
        set(`MOD_CARRIER_LOW_ADDR, 8'h40, 1'b1);
        set(`MOD_CARRIER_LOW_ADDR, 8'h41, 1'b0);
        set(`MOD_CTRL_ADDR, 8'h91, 1'b0);
        set(`MOD_CARRIER_HIGH_ADDR, 8'h41, 1'b1);
        set(`MOD_CTRL_ADDR, 8'h80, 1'b0);
        set(`MOD_CARRIER_HIGH_ADDR, 8'h01, 1'b0);
        set(`MOD_SRC_ADDR, 8'h01, 1'b1);
        set(`MOD_SRC_ADDR, 8'h02, 1'b0);
        rchk(`MOD_SRC_ADDR, 32'h02);
    endtask : sc_mixing
    task automatic sc_reset_mid;
        set(`MOD_CTRL_ADDR, 8'h90, 1'b1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(`MOD_CTRL_ADDR, 32'h0);
        rchk(`MOD_CARRIER_LOW_ADDR, 32'h0);
        set(`MOD_SRC_ADDR, 8'h00, 1'b0);
    endtask : sc_reset_mid
    // sync entry and exit held on a steady carrier, exit released on the toggling carrier, then unsynced tracking
    task automatic sc_sync;
        logic prev;
        set(`MOD_CARRIER_HIGH_ADDR, 8'h21, 1'b0);
        set(`MOD_CTRL_ADDR, 8'h81, 1'b0);
        set(`MOD_CARRIER_HIGH_ADDR, 8'h01, 1'b1);
        set(`MOD_CARRIER_HIGH_ADDR, 8'h21, 1'b1);
        set(`MOD_CTRL_ADDR, 8'h80, 1'b1);
        wr(`MOD_CARRIER_HIGH_ADDR, 8'h22, 4'hf);
        repeat (12) @(posedge clk_sys);
        repeat (16)
        begin
            @(negedge clk_sys);
            cmp("sync_release", 32'h0, {31'h0, mod_out});
        end
        set(`MOD_CARRIER_HIGH_ADDR, 8'h01, 1'b0);
        wr(`MOD_SRC_ADDR, 8'h03, 4'hf);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        prev = msrc[3];
        repeat (8)
        begin
            @(negedge clk_sys);
            cmp("track", {31'h0, prev}, {31'h0, mod_out});
            prev = msrc[3];
        end
        @(posedge clk_sys);
    endtask : sc_sync
    // reset, then the scenarios
    initial
    begin
        sys_rst = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        bready = 1'b1;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        sc_reset_values();
        sc_idle_level();
        sc_mixing();
        sc_reset_mid();
        sc_sync();
        print_verdict();
    end
endmodule : signal_modulator_tb
